// ### pkg/adc_cfg_defs.vh
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH
// register byte addresses on the bus
`define ADDR_EXT_CONFIG      8'h00
`define ADDR_MODE            8'h04
`define ADDR_THRESHOLD       8'h08
`define ADDR_THR_LIMIT       8'h0c
`define ADDR_THR_VALUE       8'h10
`define ADDR_RES_LIMIT       8'h14
`define ADDR_RES_VALUE       8'h18
`define ADDR_ACCUM           8'h1c
`define ADDR_STATUS          8'h20
`define ADDR_VT_RESULT       8'h24
// extended configuration and mode fields
`define CFG_GND_BIT          7
`define CFG_ACC_HI           6
`define CFG_ACC_LO           5
`define CFG_CMP_HI           4
`define CFG_CMP_LO           3
`define CFG_OVR_BIT          2
`define CFG_RSV_BIT          1
`define CFG_RCNT_BIT         0
`define MODE_RES_BIT         6
`define MODE_UNIPOLAR_BIT    5
// status bits
`define STA_RESULT_BIT       0
`define STA_THRESH_BIT       1
`define STA_OVR_BIT          2
// reset values
`define RST_EXT_CONFIG       8'h00
`define RST_MODE             8'h00
`define RST_THRESHOLD        16'h0000
`define RST_THR_LIMIT        8'h01
`define RST_RES_LIMIT        16'h0001
// codes
`define ACC_OFF              2'b00
`define ACC_CLAMP            2'b01
`define ACC_SIGNED           2'b10
`define CMP_OFF              2'b00
`define CMP_SINGLE           2'b01
`define CMP_COUNT_RST        2'b10
`define CMP_COUNT_DEC        2'b11
// timing
`define CLK_HZ               20000000
`define OVR_PERSIST_US       125
`define OVR_PERSIST_CYC      ((`OVR_PERSIST_US * (`CLK_HZ / 1000000)) + 1)
`endif

// ### tb/adc_pp_checker.sv
`timescale 1ns/10ps
module adc_pp_checker
#(
  parameter OVR_CYCLES = 20
)
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // results and outputs
  input wire        cur_valid,
  input wire        coarse_over_pin,
  input wire        gnd_switch_direct,
  input wire        gnd_switch_resistor,
  input wire        adc_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // raw pin high time; the filter also sees sync delay, so this is a lower bound
  reg [15:0] pin_cnt;
  always @(posedge aclk)
    if (!aresetn || !coarse_over_pin)
      pin_cnt <= 16'h0;
    else if (pin_cnt != 16'hffff)
      pin_cnt <= pin_cnt + 16'h1;
  ////////////////////////////////////////
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_resp_a: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response after both channels");
  aw_taken_a: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("write address taken without valid");
  read_answer_a: assert property ($rose(s_axi_arvalid) |=> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not answered in time");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  gnd_path_a: assert property (!(gnd_switch_direct && gnd_switch_resistor))
    else $error("both ground paths closed");
  irq_cause_a: assert property ($rose(adc_irq) |-> $past(cur_valid, 2) || pin_cnt >= OVR_CYCLES)
    else $error("interrupt without result or persisted overrange");
  reset_quiet_a: assert property ($rose(aresetn) |-> !adc_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active at reset release");
  c_write_c: cover property (s_axi_bvalid && s_axi_bready);
  c_refuse_c: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_irq_c: cover property ($rose(adc_irq));
endmodule // adc_pp_checker

bind current_adc_postprocess adc_pp_checker #(.OVR_CYCLES(OVR_CYCLES)) adc_pp_checker_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cur_valid, .coarse_over_pin,
  .gnd_switch_direct, .gnd_switch_resistor, .adc_irq);

// ### tb/current_adc_postprocess_tb.sv
`timescale 1ns/10ps
module current_adc_postprocess_tb;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, r32, acc;
  reg         cur_valid, vt_valid, coarse_over_pin;
  reg  [15:0] cur_data, vt_data, d16;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        gnd_switch_direct, gnd_switch_resistor, adc_irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     fail_count, checks, seed, i;
  reg  [33:0] exp_q [$];
  reg  [1:0]  exp_b [$];
  localparam [15:0] HI = 16'h0200;
  localparam [15:0] LO = 16'h0010;
  current_adc_postprocess #(.OVR_CYCLES(20)) current_adc_postprocess_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cur_valid, .cur_data, .vt_valid, .vt_data, .coarse_over_pin,
    .gnd_switch_direct, .gnd_switch_resistor, .adc_irq);
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////
  task chk(input string what, input [33:0] exp, input [33:0] got);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task tmo;
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED handshake expected answer seen none");
      end_of_test;
    end
  endtask
  // master holds each channel until its own ready
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    integer n;
    begin
      @(posedge aclk);
      exp_b.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n = n + 1)
      begin
        @(posedge aclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
      if (n == 40)
        tmo;
      s_axi_bready <= 1'b0;
    end
  endtask
  // expectation queued here, compared by the read monitor
  task rd(input [7:0] a, input [1:0] r, input [31:0] d);
    integer n;
    begin
      @(posedge aclk);
      exp_q.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n = n + 1)
      begin
        @(posedge aclk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end
      if (n == 40)
        tmo;
      s_axi_rready <= 1'b0;
    end
  endtask
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  always @(posedge aclk)
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", 34'(exp_b.pop_front()), 34'(s_axi_bresp));
  task res(input [15:0] d);
    begin
      @(posedge aclk);
      cur_data <= d;
      cur_valid <= 1'b1;
      @(posedge aclk);
      cur_valid <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
  task gnd(input dir, input rs);
    begin
      repeat (2) @(posedge aclk);
      chk("direct", 34'(dir), 34'(gnd_switch_direct));
      chk("resistor", 34'(rs), 34'(gnd_switch_resistor));
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    seed = 70453;
    fail_count = 0;
    checks = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {cur_valid, vt_valid, coarse_over_pin, cur_data, vt_data} = 35'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 2'b00, 32'h0);
    rd(8'h0c, 2'b00, 32'h1);
    rd(8'h14, 2'b00, 32'h1);
    rd(8'h28, 2'b10, 32'h0);
    wr(8'h1c, 32'h5, 2'b10);
    wr(8'h00, 32'h80, 2'b00);
    gnd(1'b1, 1'b0);
    wr(8'h04, 32'h40, 2'b00);
    gnd(1'b0, 1'b1);
    wr(8'h00, 32'h00, 2'b00);
    gnd(1'b0, 1'b0);
    wr(8'h04, 32'h00, 2'b00);
    wr(8'h00, 32'h20, 2'b00);
    res(16'd100);
    res(16'hfed4);
    res(16'd50);
    rd(8'h1c, 2'b00, 32'd50);
    wr(8'h00, 32'h00, 2'b00);
    res(16'd7);
    res(16'd7);
    rd(8'h1c, 2'b00, 32'h0);
    wr(8'h00, 32'h40, 2'b00);
    acc = 32'hfffffed4;
    res(16'hfed4);
    for (i = 0; i < 8; i = i + 1)
    begin
      r32 = $random(seed);
      d16 = r32[15:0];
      acc = acc + {{16{d16[15]}}, d16};
      res(d16);
    end
    rd(8'h1c, 2'b00, acc);
    wr(8'h00, 32'h60, 2'b00);
    res(16'd500);
    rd(8'h1c, 2'b00, acc);
    rd(8'h20, 2'b00, 32'h1);
    wr(8'h00, 32'h08, 2'b00);
    wr(8'h08, 32'h100, 2'b00);
    res(16'h0100);
    rd(8'h20, 2'b00, 32'h3);
    res(16'hff00);
    rd(8'h20, 2'b00, 32'h3);
    res(16'h00ff);
    rd(8'h20, 2'b00, 32'h1);
    wr(8'h04, 32'h20, 2'b00);
    wr(8'h08, 32'h8100, 2'b00);
    res(16'h80ff);
    rd(8'h20, 2'b00, 32'h1);
    wr(8'h04, 32'h00, 2'b00);
    res(16'h0100);
    rd(8'h20, 2'b00, 32'h3);
    wr(8'h08, 32'h100, 2'b00);
    wr(8'h0c, 32'h2, 2'b00);
    wr(8'h00, 32'h10, 2'b00);
    res(LO);
    res(HI);
    res(LO);
    res(HI);
    rd(8'h10, 2'b00, 32'h1);
    rd(8'h20, 2'b00, 32'h1);
    res(HI);
    rd(8'h20, 2'b00, 32'h3);
    wr(8'h00, 32'h18, 2'b00);
    res(LO);
    res(LO);
    res(LO);
    rd(8'h10, 2'b00, 32'h0);
    res(HI);
    res(HI);
    res(LO);
    rd(8'h10, 2'b00, 32'h1);
    rd(8'h20, 2'b00, 32'h3);
    wr(8'h14, 32'h3, 2'b00);
    wr(8'h00, 32'h01, 2'b00);
    res(LO);
    res(LO);
    rd(8'h18, 2'b00, 32'h2);
    chk("irq", 34'h0, 34'(adc_irq));
    for (i = 1; i < 3; i = i + 1)
    begin
      @(posedge aclk);
      vt_data <= i[15:0] * 16'h1111;
      vt_valid <= 1'b1;
      @(posedge aclk);
      vt_valid <= 1'b0;
    end
    res(LO);
    chk("irq", 34'h1, 34'(adc_irq));
    rd(8'h20, 2'b00, 32'h1);
    rd(8'h18, 2'b00, 32'h0);
    rd(8'h24, 2'b00, 32'h2222);
    res(LO);
    wr(8'h00, 32'h01, 2'b00);
    rd(8'h18, 2'b00, 32'h0);
    wr(8'h00, 32'h04, 2'b00);
    // a short excursion must not survive the persistence filter
    coarse_over_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    coarse_over_pin <= 1'b0;
    rd(8'h20, 2'b00, 32'h0);
    coarse_over_pin <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("irq", 34'h1, 34'(adc_irq));
    coarse_over_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h20, 2'b00, 32'h4);
    wr(8'h00, 32'h00, 2'b00);
    coarse_over_pin <= 1'b1;
    repeat (40) @(posedge aclk);
    coarse_over_pin <= 1'b0;
    rd(8'h20, 2'b00, 32'h0);
    repeat (2) @(posedge aclk);
    chk("pending", 34'h0, 34'(exp_q.size() + exp_b.size()));
    end_of_test;
  end
endmodule // current_adc_postprocess_tb

// ### verilog/current_adc_postprocess.v
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "adc_cfg_defs.vh"
//
// Contract
// - config bit 7 connects switched ground pin to analog ground.
// - ground switch with mode bit 6 selects resistor path.
// - accumulator code 00 disables and holds accumulator at zero.
// - code 01 adds positives, subtracts negatives, clamps at zero.
// - code 10 adds positives, subtracts magnitudes, may go negative.
// - active accumulator wraps on overflow, no top saturation.
// - comparator 00 off; 01 interrupts each result at or above threshold.
// - code 10 interrupts at count limit; below threshold zeroes counter.
// - code 11 counts likewise; below threshold decrements, floor zero.
// - bit 2 enables coarse overrange detection setting status flag.
// - overrange flag sets only after condition persists over 125 us.
// - bit 0 suppresses result-ready interrupts until result count equals limit.
// - result count mode keeps only latest voltage/temperature result.
// - count resets at limit; config or mode write clears it.
// - threshold counter increments on each at-or-above result while comparator on, holding at ff.
// - compare 16 threshold bits unipolar, 15 bits twos complement.
module current_adc_postprocess
#(
  parameter OVR_CYCLES = `OVR_PERSIST_CYC
)
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address / data / response
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // converter results, same clock
  input  wire        cur_valid,
  input  wire [15:0] cur_data,
  input  wire        vt_valid,
  input  wire [15:0] vt_data,
  // coarse comparator pin, asynchronous
  input  wire        coarse_over_pin,
  // ground switch and interrupt
  output reg         gnd_switch_direct,
  output reg         gnd_switch_resistor,
  output reg         adc_irq
);
  reg  [7:0]  cfg_reg;
  reg  [7:0]  mode_reg;
  reg  [15:0] thresh_reg;
  reg  [7:0]  thr_limit_reg;
  reg  [7:0]  thr_value_reg;
  reg  [15:0] res_limit_reg;
  reg  [15:0] res_value_reg;
  reg  [31:0] accum_reg;
  reg  [2:0]  status_reg;
  reg  [15:0] vt_latest_reg;
  reg  [15:0] vt_reg;
  reg         ovr_s1_reg;
  reg         ovr_s2_reg;
  reg         aw_hold_reg;
  reg         w_hold_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire        ovr_persist;
  wire [1:0]  acc_mode  = cfg_reg[`CFG_ACC_HI:`CFG_ACC_LO];
  wire [1:0]  cmp_mode  = cfg_reg[`CFG_CMP_HI:`CFG_CMP_LO];
  wire        unipolar  = mode_reg[`MODE_UNIPOLAR_BIT];

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // result magnitude and threshold compare
  wire        neg       = !unipolar && cur_data[15];
  wire [15:0] mag       = neg ? (~cur_data + 16'h0001) : cur_data;
  wire        at_or_above = unipolar ? (mag >= thresh_reg) : (mag >= {1'b0, thresh_reg[14:0]});
  wire [31:0] mag32     = {16'h0000, mag};
  wire [31:0] acc_add   = accum_reg + mag32;
  wire [31:0] acc_sub   = accum_reg - mag32;

  ////////////////////////////////////////////////////////////////////////////
  // overrange: pin synchronised, then filtered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovr_s1_reg <= 1'b0;
      ovr_s2_reg <= 1'b0;
    end
    else
    begin
      ovr_s1_reg <= coarse_over_pin;
      ovr_s2_reg <= ovr_s1_reg;
    end
  end

  overrange_filter #(.CYCLES(OVR_CYCLES), .CW(13)) u_ovr
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (cfg_reg[`CFG_OVR_BIT]),
    .cond      (ovr_s2_reg),
    .persisted (ovr_persist)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  wire        do_read  = s_axi_arvalid && s_axi_arready;
  wire        rd_status = do_read && s_axi_araddr == `ADDR_STATUS;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
    end
    else
    begin
      // one-cycle ready pulses; each channel captured when seen
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_hold_reg && !s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_hold_reg && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_hold_reg && w_hold_reg && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (w_addr_known(aw_addr_reg)) ? 2'b00 : 2'b10;
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `ADDR_VT_RESULT) ? 2'b00 : 2'b10;
        case (s_axi_araddr)
          `ADDR_EXT_CONFIG: s_axi_rdata <= {24'h000000, cfg_reg};
          `ADDR_MODE:       s_axi_rdata <= {24'h000000, mode_reg};
          `ADDR_THRESHOLD:  s_axi_rdata <= {16'h0000, thresh_reg};
          `ADDR_THR_LIMIT:  s_axi_rdata <= {24'h000000, thr_limit_reg};
          `ADDR_THR_VALUE:  s_axi_rdata <= {24'h000000, thr_value_reg};
          `ADDR_RES_LIMIT:  s_axi_rdata <= {16'h0000, res_limit_reg};
          `ADDR_RES_VALUE:  s_axi_rdata <= {16'h0000, res_value_reg};
          `ADDR_ACCUM:      s_axi_rdata <= accum_reg;
          `ADDR_STATUS:     s_axi_rdata <= {29'h00000000, status_reg};
          `ADDR_VT_RESULT:  s_axi_rdata <= {16'h0000, vt_reg};
          default:          s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  function w_addr_known;
    input [7:0] a;
    begin
      w_addr_known = (a == `ADDR_EXT_CONFIG) || (a == `ADDR_MODE) || (a == `ADDR_THRESHOLD) ||
                     (a == `ADDR_THR_LIMIT) || (a == `ADDR_RES_LIMIT);
    end
  endfunction

  // writes commit when both channels are held; registers update on the same edge that raises bvalid
  wire commit = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire c_cfg  = commit && aw_addr_reg == `ADDR_EXT_CONFIG && w_strb_reg[0];
  wire c_mode = commit && aw_addr_reg == `ADDR_MODE && w_strb_reg[0];

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg       <= `RST_EXT_CONFIG;
      mode_reg      <= `RST_MODE;
      thresh_reg    <= `RST_THRESHOLD;
      thr_limit_reg <= `RST_THR_LIMIT;
      res_limit_reg <= `RST_RES_LIMIT;
    end
    else if (commit)
    begin
      // reserved bit stored as written; software is expected to keep it zero
      if (c_cfg)
        cfg_reg <= w_data_reg[7:0];
      if (c_mode)
        mode_reg <= w_data_reg[7:0];
      if (aw_addr_reg == `ADDR_THRESHOLD)
        thresh_reg <= merge16(thresh_reg, w_data_reg, w_strb_reg);
      if (aw_addr_reg == `ADDR_THR_LIMIT && w_strb_reg[0])
        thr_limit_reg <= w_data_reg[7:0];
      if (aw_addr_reg == `ADDR_RES_LIMIT)
        res_limit_reg <= merge16(res_limit_reg, w_data_reg, w_strb_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-result processing
  wire [7:0]  thr_inc   = (thr_value_reg == 8'hff) ? thr_value_reg : thr_value_reg + 8'h01;
  wire [15:0] res_inc   = res_value_reg + 16'h0001;
  wire        res_hit   = cur_valid && cfg_reg[`CFG_RCNT_BIT] && res_inc == res_limit_reg;
  wire        thr_event = cur_valid && at_or_above &&
                          ((cmp_mode == `CMP_SINGLE) ||
                           ((cmp_mode == `CMP_COUNT_RST || cmp_mode == `CMP_COUNT_DEC) &&
                            thr_inc >= thr_limit_reg));

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      accum_reg     <= 32'h0000_0000;
      thr_value_reg <= 8'h00;
      res_value_reg <= 16'h0000;
      status_reg    <= 3'b000;
      vt_latest_reg <= 16'h0000;
      vt_reg        <= 16'h0000;
      adc_irq       <= 1'b0;
    end
    else
    begin
      if (acc_mode == `ACC_OFF)
        accum_reg <= 32'h0000_0000;
      else if (cur_valid)
      begin
        if (!neg && acc_mode != 2'b11)
          accum_reg <= acc_add;
        else if (acc_mode == `ACC_CLAMP)
          accum_reg <= (mag32 > accum_reg) ? 32'h0000_0000 : acc_sub;
        else if (acc_mode == `ACC_SIGNED)
          accum_reg <= acc_sub;
        else
          accum_reg <= accum_reg;
      end

      if (cur_valid && cmp_mode != `CMP_OFF)
      begin
        if (at_or_above)
          thr_value_reg <= thr_inc;
        else if (cmp_mode == `CMP_COUNT_RST)
          thr_value_reg <= 8'h00;
        else if (cmp_mode == `CMP_COUNT_DEC && thr_value_reg != 8'h00)
          thr_value_reg <= thr_value_reg - 8'h01;
      end

      // clear on reconfigure, wrap at limit
      if (c_cfg || c_mode)
        res_value_reg <= 16'h0000;
      else if (cur_valid && cfg_reg[`CFG_RCNT_BIT])
        res_value_reg <= res_hit ? 16'h0000 : res_inc;

      // latest voltage result kept, published on counter interrupt, or on each result with counter off
      if (vt_valid)
        vt_latest_reg <= vt_data;
      if (!cfg_reg[`CFG_RCNT_BIT] && vt_valid)
        vt_reg <= vt_data;
      else if (res_hit)
        vt_reg <= vt_valid ? vt_data : vt_latest_reg;

      // status: hardware set wins over the read clear
      // result-ready gated by counter
      status_reg[`STA_RESULT_BIT] <= (cur_valid && (!cfg_reg[`CFG_RCNT_BIT] || res_hit)) ||
                                     (status_reg[`STA_RESULT_BIT] && !rd_status);
      status_reg[`STA_THRESH_BIT] <= thr_event || (status_reg[`STA_THRESH_BIT] && !rd_status);
      status_reg[`STA_OVR_BIT]    <= ovr_persist || (status_reg[`STA_OVR_BIT] && !rd_status);
      adc_irq <= |status_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ground switch
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gnd_switch_direct   <= 1'b0;
      gnd_switch_resistor <= 1'b0;
    end
    else
    begin
      gnd_switch_direct   <= cfg_reg[`CFG_GND_BIT] && !mode_reg[`MODE_RES_BIT];
      gnd_switch_resistor <= cfg_reg[`CFG_GND_BIT] && mode_reg[`MODE_RES_BIT];
    end
  end
endmodule // current_adc_postprocess

// ### verilog/overrange_filter.v
`timescale 1ns/10ps
`include "adc_cfg_defs.vh"
module overrange_filter
#(
  parameter CYCLES = `OVR_PERSIST_CYC,
  parameter CW     = 13
)
(
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // condition in, persisted level out
  input  wire enable,
  input  wire cond,
  output reg  persisted
);
  reg [CW-1:0] count_reg;
  always @(posedge aclk)
  begin
    if (!aresetn || !enable || !cond)
    begin
      count_reg <= {CW{1'b0}};
      persisted <= 1'b0;
    end
    else if (count_reg == CYCLES[CW-1:0])
    begin
      persisted <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // overrange_filter
